// File: shared/cwp_pkg.sv
// Purpose: constants, field layouts and types of the configuration decoder
// Assumes: 14-bit configuration words, APB register index = byte address / 4
// Notes: bit positions follow the configuration word layouts
package cwp_pkg;

  // ----------------------------------------------------------------
  // Widths and blank values
  // ----------------------------------------------------------------
  localparam int WORD_W = 14;
  localparam int APB_AW = 18;
  localparam int IDX_W = 16;
  localparam int CPU_AW = 13;
  localparam logic [WORD_W-1:0] BLANK_WORD = 14'h3FFF;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_UID0 = 16'h8000;
  localparam logic [IDX_W-1:0] IDX_UID3 = 16'h8003;
  localparam logic [IDX_W-1:0] IDX_IDWORD = 16'h8006;
  localparam logic [IDX_W-1:0] IDX_CFG1 = 16'h8007;
  localparam logic [IDX_W-1:0] IDX_CFG2 = 16'h8008;
  localparam logic [IDX_W-1:0] IDX_ERASE = 16'h8010;
  localparam logic [IDX_W-1:0] IDX_STATUS = 16'h8011;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OSC_LSB = 0;
  localparam int PMP_BIT = 7;
  localparam int EEP_BIT = 8;
  localparam int LOWV_BIT = 13;
  localparam int DBG_BIT = 12;
  localparam int BOR_BIT = 10;
  localparam int STV_BIT = 9;
  localparam int PLL_BIT = 8;
  localparam int VCAP_LSB = 4;
  localparam int SWP_LSB = 0;
  localparam int PART_LSB = 5;
  localparam int PART_W = 9;
  localparam int REV_W = 5;
  localparam int ERASE_GO_BIT = 0;
  localparam int ST_REFUSED_BIT = 0;
  localparam int ST_LOWV_ENTRY_BIT = 1;
  localparam logic [WORD_W-1:0] CFG2_UNIMPL_MASK = 14'h08CC;
  localparam logic [1:0] VCAP_FORCED = 2'h3;

  // ----------------------------------------------------------------
  // Self-write protection limits (addresses below are protected)
  // ----------------------------------------------------------------
  localparam logic [WORD_W-1:0] WP_LIM_NONE = 14'h0000;
  localparam logic [WORD_W-1:0] WP_LIM_BOOT = 14'h0200;
  localparam logic [WORD_W-1:0] WP_LIM_HALF_4K = 14'h0800;
  localparam logic [WORD_W-1:0] WP_LIM_HALF_8K = 14'h1000;
  localparam logic [WORD_W-1:0] WP_LIM_ALL_4K = 14'h1000;
  localparam logic [WORD_W-1:0] WP_LIM_ALL_8K = 14'h2000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    OSC_LOW_POWER_CRYSTAL_MODE = 8'h01,
    OSC_MEDIUM_CRYSTAL_MODE = 8'h02,
    OSC_HIGH_SPEED_CRYSTAL_MODE = 8'h04,
    OSC_EXTERNAL_RC_MODE = 8'h08,
    OSC_INTERNAL_OSCILLATOR_MODE = 8'h10,
    OSC_EXT_CLOCK_LOW_POWER = 8'h20,
    OSC_EXT_CLOCK_MEDIUM_POWER = 8'h40,
    OSC_EXT_CLOCK_HIGH_POWER = 8'h80
  } cwp_osc_t;

  typedef enum logic [3:0] {
    CAP_ON_PORTA0 = 4'h1,
    CAP_ON_PORTA5 = 4'h2,
    CAP_ON_PORTA6 = 4'h4,
    CAP_ON_NONE = 4'h8
  } cwp_cap_t;

  typedef struct packed {
    cwp_osc_t osc_select_field;
    logic low_voltage_prog_enable;
    logic dbg_pins_gpio;
    logic brownout_threshold_select;
    logic stack_fault_reset_enable;
    logic multiplier_enable;
    cwp_cap_t regulator_cap_pin_select;
    logic [1:0] self_write_protect_field;
    logic program_code_protect;
    logic data_eeprom_protect;
  } cwp_settings_t;

  typedef struct packed {
    logic stb;
    logic sel_word2;
    logic [WORD_W-1:0] data;
  } cwp_nvprog_t;

  function automatic logic [WORD_W-1:0] cwp_wp_limit(input logic [1:0] f, input logic big);
    logic [WORD_W-1:0] lim;
    lim = WP_LIM_NONE;
    unique case (f)
      2'h3: lim = WP_LIM_NONE;
      2'h2: lim = WP_LIM_BOOT;
      2'h1: lim = big ? WP_LIM_HALF_8K : WP_LIM_HALF_4K;
      2'h0: lim = big ? WP_LIM_ALL_8K : WP_LIM_ALL_4K;
    endcase
    return lim;
  endfunction

endpackage

// File: src/cwp_decode.sv
// Purpose: configuration word shadowing, decode and external-access protection
// Assumes: NV array words are stable while SYS_RST is high; APB zero-wait slave
// Notes: programmed words take effect only at the next reset

module cwp_decode import cwp_pkg::*; #(
  parameter int APB_ADDR_W = APB_AW,
  parameter logic MEM_8KW = 1'b0,
  parameter logic LV_ONLY = 1'b0,
  // Arbitrary identification values
  parameter logic [PART_W-1:0] PART_CODE = 9'h0A5,
  parameter logic [REV_W-1:0] REV_CODE = 5'h01
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // APB register port
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [APB_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Non-volatile configuration array
  input wire logic [WORD_W-1:0] NV_CFG1,
  input wire logic [WORD_W-1:0] NV_CFG2,
  output cwp_nvprog_t NV_PROG,
  output logic NV_BULK_ERASE,
  // Programming entry pin
  input wire logic LOWV_ENTRY_PIN,
  // Decoded settings
  output cwp_settings_t SETTINGS,
  output logic HV_PROG_REQUIRED,
  input wire logic STACK_FAULT,
  output logic STACK_RESET,
  // External program memory access
  input wire logic EXT_PM_RD,
  input wire logic EXT_PM_WR,
  input wire logic [WORD_W-1:0] PM_ARRAY_DATA,
  output logic [WORD_W-1:0] EXT_PM_RDATA,
  output logic PM_EXT_WE,
  output logic PM_ERASE_ALL,
  // External data EEPROM access
  input wire logic EXT_EE_RD,
  input wire logic EXT_EE_WR,
  input wire logic [7:0] EE_ARRAY_DATA,
  output logic [7:0] EXT_EE_RDATA,
  output logic EE_EXT_WE,
  output logic EE_ERASE_ALL,
  // CPU self-write request
  input wire logic CPU_SW_REQ,
  input wire logic [CPU_AW-1:0] CPU_SW_ADDR,
  output logic CPU_SW_GRANT
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  initial begin
    if (APB_ADDR_W < APB_AW) begin
      $error("APB address too narrow for configuration space");
    end
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] cfg1_q;
  logic [WORD_W-1:0] cfg2_q;
  logic [WORD_W-1:0] uid_q [4];
  logic [WORD_W-1:0] id_word;
  logic [WORD_W-1:0] prog_d;
  logic lowv_entry;
  logic refused_q;
  logic [IDX_W-1:0] idx;
  logic aligned;
  logic setup;
  logic wr_go;
  logic bad_addr;
  logic bulk_go;
  logic cfg1_wr;
  logic cfg2_wr;
  logic lowv_clear_try;
  logic [1:0] cap_code;
  logic [WORD_W-1:0] wp_limit;
  cwp_settings_t set_d;

  function automatic logic is_uid(input logic [IDX_W-1:0] i);
    return (i >= IDX_UID0) && (i <= IDX_UID3);
  endfunction

  function automatic logic is_mapped(input logic [IDX_W-1:0] i);
    return is_uid(i) || (i == IDX_IDWORD) || (i == IDX_CFG1) || (i == IDX_CFG2)
      || (i == IDX_ERASE) || (i == IDX_STATUS);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  cwp_sync #(
    .W(1)
  ) u_lvp_sync (
    .clk(CLK),
    .rst(SYS_RST),
    .d(LOWV_ENTRY_PIN),
    .q(lowv_entry)
  );

  // ----------------------------------------------------------------
  // Shadow capture
  // ----------------------------------------------------------------
  // Shadows follow the array only while reset is held, so the decode
  // cannot shift under running logic when the array is reprogrammed.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cfg1_q <= NV_CFG1;
      cfg2_q <= NV_CFG2 | CFG2_UNIMPL_MASK;
      if (LV_ONLY) begin
        cfg2_q[VCAP_LSB +: 2] <= VCAP_FORCED;
      end
    end
  end

  // ----------------------------------------------------------------
  // Setting decode
  // ----------------------------------------------------------------
  assign cap_code = cfg2_q[VCAP_LSB +: 2];

  always_comb begin
    set_d = '0;
    unique case (cfg1_q[OSC_LSB +: 3])
      3'h7: set_d.osc_select_field = OSC_EXT_CLOCK_HIGH_POWER;
      3'h6: set_d.osc_select_field = OSC_EXT_CLOCK_MEDIUM_POWER;
      3'h5: set_d.osc_select_field = OSC_EXT_CLOCK_LOW_POWER;
      3'h4: set_d.osc_select_field = OSC_INTERNAL_OSCILLATOR_MODE;
      3'h3: set_d.osc_select_field = OSC_EXTERNAL_RC_MODE;
      3'h2: set_d.osc_select_field = OSC_HIGH_SPEED_CRYSTAL_MODE;
      3'h1: set_d.osc_select_field = OSC_MEDIUM_CRYSTAL_MODE;
      3'h0: set_d.osc_select_field = OSC_LOW_POWER_CRYSTAL_MODE;
    endcase
    unique case (cap_code)
      2'h0: set_d.regulator_cap_pin_select = CAP_ON_PORTA0;
      2'h1: set_d.regulator_cap_pin_select = CAP_ON_PORTA5;
      2'h2: set_d.regulator_cap_pin_select = CAP_ON_PORTA6;
      2'h3: set_d.regulator_cap_pin_select = CAP_ON_NONE;
    endcase
    set_d.low_voltage_prog_enable = cfg2_q[LOWV_BIT];
    set_d.dbg_pins_gpio = cfg2_q[DBG_BIT];
    set_d.brownout_threshold_select = cfg2_q[BOR_BIT];
    set_d.stack_fault_reset_enable = cfg2_q[STV_BIT];
    set_d.multiplier_enable = cfg2_q[PLL_BIT];
    set_d.self_write_protect_field = cfg2_q[SWP_LSB +: 2];
    set_d.program_code_protect = cfg1_q[PMP_BIT];
    set_d.data_eeprom_protect = cfg1_q[EEP_BIT];
  end

  // Registered outputs; shadows settle during reset, so the lag is unseen
  always_ff @(posedge CLK) begin
    SETTINGS <= set_d;
    HV_PROG_REQUIRED <= ~cfg2_q[LOWV_BIT];
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      STACK_RESET <= 1'b0;
    end else begin
      STACK_RESET <= STACK_FAULT & cfg2_q[STV_BIT];
    end
  end

  // ----------------------------------------------------------------
  // External memory protection
  // ----------------------------------------------------------------
  // Only the external path is gated; CPU reads never pass through here.
  assign PM_EXT_WE = EXT_PM_WR & cfg1_q[PMP_BIT];
  assign EE_EXT_WE = EXT_EE_WR & cfg1_q[EEP_BIT];

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      EXT_PM_RDATA <= '0;
    end else if (EXT_PM_RD) begin
      EXT_PM_RDATA <= cfg1_q[PMP_BIT] ? PM_ARRAY_DATA : '0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      EXT_EE_RDATA <= '0;
    end else if (EXT_EE_RD) begin
      EXT_EE_RDATA <= cfg1_q[EEP_BIT] ? EE_ARRAY_DATA : '0;
    end
  end

  // ----------------------------------------------------------------
  // Self-write protection
  // ----------------------------------------------------------------
  assign wp_limit = cwp_wp_limit(cfg2_q[SWP_LSB +: 2], MEM_8KW);
  // Protection field alone decides; code protect plays no part.
  assign CPU_SW_GRANT = CPU_SW_REQ & ({1'b0, CPU_SW_ADDR} >= wp_limit);

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign idx = PADDR[IDX_W+1:2];
  assign aligned = (PADDR[1:0] == 2'h0);
  assign setup = PSEL & ~PENABLE;
  assign bad_addr = ~aligned | ~is_mapped(idx);
  assign PREADY = PSEL & PENABLE;
  assign PSLVERR = PSEL & PENABLE & bad_addr;
  assign wr_go = PSEL & PENABLE & PWRITE & ~bad_addr;
  assign bulk_go = wr_go & (idx == IDX_ERASE) & PWDATA[ERASE_GO_BIT];
  assign cfg1_wr = wr_go & (idx == IDX_CFG1);
  assign cfg2_wr = wr_go & (idx == IDX_CFG2);
  assign lowv_clear_try = cfg2_wr & lowv_entry & ~PWDATA[LOWV_BIT];
  assign id_word = {PART_CODE, REV_CODE};

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Captured in the setup cycle so PRDATA is a flop during access.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      PRDATA <= ZERO_WORD;
    end else if (setup) begin
      PRDATA <= ZERO_WORD;
      if (!PWRITE && aligned) begin
        if (is_uid(idx)) begin
          PRDATA[WORD_W-1:0] <= uid_q[idx[1:0]];
        end else begin
          unique case (idx)
            IDX_IDWORD: PRDATA[WORD_W-1:0] <= id_word;
            IDX_CFG1: PRDATA[WORD_W-1:0] <= cfg1_q;
            IDX_CFG2: PRDATA[WORD_W-1:0] <= cfg2_q;
            IDX_STATUS: begin
              PRDATA[ST_REFUSED_BIT] <= refused_q;
              PRDATA[ST_LOWV_ENTRY_BIT] <= lowv_entry;
            end
            default: PRDATA <= ZERO_WORD;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // User ID words
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      for (int i = 0; i < 4; i++) begin
        uid_q[i] <= BLANK_WORD;
      end
    end else if (bulk_go) begin
      for (int i = 0; i < 4; i++) begin
        uid_q[i] <= BLANK_WORD;
      end
    end else if (wr_go && is_uid(idx)) begin
      uid_q[idx[1:0]] <= PWDATA[WORD_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Configuration programming
  // ----------------------------------------------------------------
  // The identification word has no write path at all.
  always_comb begin
    prog_d = PWDATA[WORD_W-1:0];
    if (cfg2_wr) begin
      prog_d = PWDATA[WORD_W-1:0] | CFG2_UNIMPL_MASK;
      if (lowv_entry) begin
        prog_d[LOWV_BIT] = 1'b1;
      end
      if (LV_ONLY) begin
        prog_d[VCAP_LSB +: 2] = VCAP_FORCED;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      NV_PROG <= '0;
    end else begin
      NV_PROG.stb <= cfg1_wr | cfg2_wr;
      if (cfg1_wr || cfg2_wr) begin
        NV_PROG.sel_word2 <= cfg2_wr;
        NV_PROG.data <= prog_d;
      end
    end
  end

  // Hardware set wins over a same-cycle clear by software.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      refused_q <= 1'b0;
    end else if (lowv_clear_try) begin
      refused_q <= 1'b1;
    end else if (wr_go && idx == IDX_STATUS && PWDATA[ST_REFUSED_BIT]) begin
      refused_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Erase sequencing
  // ----------------------------------------------------------------
  // Bulk erase returns every array bit to one, which turns both
  // protections off; program memory is wiped with them, the EEPROM only if its protection was on.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      NV_BULK_ERASE <= 1'b0;
      PM_ERASE_ALL <= 1'b0;
      EE_ERASE_ALL <= 1'b0;
    end else begin
      NV_BULK_ERASE <= bulk_go;
      PM_ERASE_ALL <= bulk_go
        | (cfg1_wr & ~cfg1_q[PMP_BIT] & PWDATA[PMP_BIT]);
      EE_ERASE_ALL <= bulk_go & ~cfg1_q[EEP_BIT];
    end
  end

endmodule

// File: src/cwp_sync.sv
// Purpose: two-stage synchroniser for levels arriving from pins
// Assumes: input is a slow level, not a pulse
// Notes: the first stage feeds only the second stage
module cwp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  initial begin
    if (W < 1) begin
      $error("cwp_sync width must be at least one");
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// File: tb/cwp_decode_chk.sv
// Purpose: port-level checks of the configuration decoder
// Assumes: one clock, synchronous active-high reset
// Notes: bound into every decoder instance below
module cwp_decode_chk import cwp_pkg::*; #(
  parameter logic MEM_8KW = 1'b0
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Settings and programming
  input wire cwp_settings_t SETTINGS,
  input wire cwp_nvprog_t NV_PROG,
  input wire logic LOWV_ENTRY_PIN,
  input wire logic HV_PROG_REQUIRED,
  input wire logic STACK_FAULT,
  input wire logic STACK_RESET,
  input wire logic PM_ERASE_ALL,
  // External and CPU access
  input wire logic EXT_PM_RD,
  input wire logic EXT_PM_WR,
  input wire logic [WORD_W-1:0] PM_ARRAY_DATA,
  input wire logic [WORD_W-1:0] EXT_PM_RDATA,
  input wire logic PM_EXT_WE,
  input wire logic EXT_EE_RD,
  input wire logic EXT_EE_WR,
  input wire logic [7:0] EXT_EE_RDATA,
  input wire logic EE_EXT_WE,
  input wire logic CPU_SW_REQ,
  input wire logic [CPU_AW-1:0] CPU_SW_ADDR,
  input wire logic CPU_SW_GRANT
);
  logic [WORD_W-1:0] lim;
  logic [2:0] lowv_cnt_q;

  // Own table of limits, kept apart from the package function
  always_comb begin
    case (SETTINGS.self_write_protect_field)
      2'h3: lim = 14'h0000;
      2'h2: lim = 14'h0200;
      2'h1: lim = MEM_8KW ? 14'h1000 : 14'h0800;
      default: lim = MEM_8KW ? 14'h2000 : 14'h1000;
    endcase
  end

  // Saturates so the synchroniser delay is surely covered
  always_ff @(posedge CLK) begin
    if (SYS_RST || !LOWV_ENTRY_PIN) begin
      lowv_cnt_q <= 3'h0;
    end else if (lowv_cnt_q != 3'h7) begin
      lowv_cnt_q <= lowv_cnt_q + 3'h1;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  a_osc_onehot: assert property ($onehot(SETTINGS.osc_select_field))
    else $error("oscillator mode not one-hot");
  a_hv_required: assert property (HV_PROG_REQUIRED != SETTINGS.low_voltage_prog_enable)
    else $error("high-voltage flag disagrees with LOW_VOLTAGE_PROG_ENABLE setting");
  a_lowv_kept: assert property (lowv_cnt_q == 3'h7 && NV_PROG.stb && NV_PROG.sel_word2
    |-> NV_PROG.data[LOWV_BIT]) else $error("low-voltage bit cleared during entry");
  a_stack_reset: assert property (STACK_FAULT
    |=> STACK_RESET == SETTINGS.stack_fault_reset_enable) else $error("stack reset wrong");
  a_word2_ones: assert property (NV_PROG.stb && NV_PROG.sel_word2
    |-> (NV_PROG.data & CFG2_UNIMPL_MASK) == CFG2_UNIMPL_MASK) else $error("word2 gaps not one");
  a_self_write: assert property (CPU_SW_GRANT
    == (CPU_SW_REQ && {1'b0, CPU_SW_ADDR} >= lim)) else $error("self-write grant wrong");
  a_pm_rd_block: assert property (EXT_PM_RD && !SETTINGS.program_code_protect
    |=> EXT_PM_RDATA == 14'h0000) else $error("protected program read leaked");
  a_pm_rd_pass: assert property (EXT_PM_RD && SETTINGS.program_code_protect
    |=> EXT_PM_RDATA == $past(PM_ARRAY_DATA)) else $error("open program read wrong");
  a_pm_wr_gate: assert property (PM_EXT_WE
    == (EXT_PM_WR && SETTINGS.program_code_protect)) else $error("program write gate wrong");
  a_ee_rd_block: assert property (EXT_EE_RD && !SETTINGS.data_eeprom_protect
    |=> EXT_EE_RDATA == 8'h00) else $error("protected eeprom read leaked");
  a_ee_wr_gate: assert property (EE_EXT_WE |-> EXT_EE_WR
    && SETTINGS.data_eeprom_protect) else $error("eeprom write gate wrong");
  a_erase_pulse: assert property (PM_ERASE_ALL |=> !PM_ERASE_ALL)
    else $error("program erase longer than one cycle");
  a_settings_hold: assert property (!$past(SYS_RST) |-> $stable(SETTINGS))
    else $error("settings moved outside reset");
endmodule

bind cwp_decode cwp_decode_chk #(.MEM_8KW(MEM_8KW)) cwp_decode_chk_i (
  .CLK, .SYS_RST, .SETTINGS, .NV_PROG, .LOWV_ENTRY_PIN, .HV_PROG_REQUIRED, .STACK_FAULT,
  .STACK_RESET, .PM_ERASE_ALL, .EXT_PM_RD, .EXT_PM_WR, .PM_ARRAY_DATA, .EXT_PM_RDATA,
  .PM_EXT_WE, .EXT_EE_RD, .EXT_EE_WR, .EXT_EE_RDATA, .EE_EXT_WE, .CPU_SW_REQ,
  .CPU_SW_ADDR, .CPU_SW_GRANT);

// File: tb/cwp_prog_model.sv
// Purpose: array side seen by the decoder: stored words and memory data
// Assumes: programmed words land one cycle after the strobe
// Notes: array data moves every cycle so a stuck read path shows
module cwp_prog_model import cwp_pkg::*; (
  // Clock
  input wire logic clk,
  // Programming side
  input wire cwp_nvprog_t prog,
  input wire logic bulk_erase,
  output logic [WORD_W-1:0] cfg1_q,
  output logic [WORD_W-1:0] cfg2_q,
  // Memory arrays
  output logic [WORD_W-1:0] pm_q,
  output logic [7:0] ee_q
);
  initial begin
    cfg1_q = BLANK_WORD;
    cfg2_q = BLANK_WORD;
    pm_q = 14'h1A5C;
    ee_q = 8'h6E;
  end

  always @(posedge clk) begin
    pm_q <= pm_q + 14'h0155;
    ee_q <= ee_q + 8'h3B;
    if (bulk_erase) begin
      cfg1_q <= BLANK_WORD;
      cfg2_q <= BLANK_WORD;
    end else if (prog.stb && prog.sel_word2) begin
      cfg2_q <= prog.data;
    end else if (prog.stb) begin
      cfg1_q <= prog.data;
    end
  end
endmodule

// File: tb/testbench.sv
// Purpose: self-checking bench for the configuration decoder
// Assumes: 4K-word part, full-voltage variant
// Notes: new configuration acts only after a reset
module testbench import cwp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary identification values
  localparam logic [PART_W-1:0] PART_T = 9'h155;
  localparam logic [REV_W-1:0] REV_T = 5'h0A;
  localparam logic [31:0] ID_T = {18'h0, PART_T, REV_T};
  int n_fail = 0, n_checks = 0, n_pmer = 0, n_eeer = 0;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic lowv_pin = 1'b0, stk = 1'b0, pm_rd = 1'b0, pm_wr = 1'b0, ee_rd = 1'b0, ee_wr = 1'b0;
  logic sw_req = 1'b0, pready, pslverr, hv, stk_rst, pm_we, pm_er, ee_we, ee_er, nv_er;
  logic grant, err_v;
  logic [CPU_AW-1:0] sw_addr = 13'h0000;
  logic [APB_AW-1:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd_v;
  logic [WORD_W-1:0] nv1, nv2, pm_arr, pm_rdata;
  logic [7:0] ee_arr, ee_rdata;
  cwp_nvprog_t nvp;
  cwp_settings_t st;

  cwp_decode #(.PART_CODE(PART_T), .REV_CODE(REV_T)) cwp_decode_i (
    .CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .NV_CFG1(nv1), .NV_CFG2(nv2), .NV_PROG(nvp), .NV_BULK_ERASE(nv_er),
    .LOWV_ENTRY_PIN(lowv_pin), .SETTINGS(st), .HV_PROG_REQUIRED(hv), .STACK_FAULT(stk),
    .STACK_RESET(stk_rst), .EXT_PM_RD(pm_rd), .EXT_PM_WR(pm_wr), .PM_ARRAY_DATA(pm_arr),
    .EXT_PM_RDATA(pm_rdata), .PM_EXT_WE(pm_we), .PM_ERASE_ALL(pm_er), .EXT_EE_RD(ee_rd),
    .EXT_EE_WR(ee_wr), .EE_ARRAY_DATA(ee_arr), .EXT_EE_RDATA(ee_rdata), .EE_EXT_WE(ee_we),
    .EE_ERASE_ALL(ee_er), .CPU_SW_REQ(sw_req), .CPU_SW_ADDR(sw_addr), .CPU_SW_GRANT(grant));

  cwp_prog_model cwp_prog_model_i (.clk(clk), .prog(nvp), .bulk_erase(nv_er),
    .cfg1_q(nv1), .cfg2_q(nv2), .pm_q(pm_arr), .ee_q(ee_arr));

  always #10 clk = ~clk;

  // Erase pulses last one cycle, so they are counted rather than polled
  always @(posedge clk) begin
    n_pmer <= n_pmer + int'(pm_er);
    n_eeer <= n_eeer + int'(ee_er);
  end

  // --------------------------------------------------------------
  // Bus and compare helpers
  // --------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdchk(input logic [IDX_W-1:0] idx, input logic [31:0] exp, input string s);
    apb(1'b0, idx, 32'h0000_0000);
    check(s, rd_v, exp);
  endtask

  task automatic do_reset(input int cyc);
    rst <= 1'b1;
    repeat (cyc) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  task automatic stack_pulse(input logic exp);
    stk <= 1'b1;
    @(posedge clk);
    stk <= 1'b0;
    @(posedge clk);
    check("stack reset", stk_rst, exp);
  endtask

  task automatic ext_acc(input logic open_pm, input logic open_ee);
    logic [WORD_W-1:0] pm_e;
    logic [7:0] ee_e;
    {pm_rd, pm_wr, ee_rd, ee_wr} <= 4'hF;
    @(posedge clk);
    pm_e = open_pm ? pm_arr : 14'h0000;
    ee_e = open_ee ? ee_arr : 8'h00;
    check("pm write enable", pm_we, open_pm);
    check("ee write enable", ee_we, open_ee);
    {pm_rd, pm_wr, ee_rd, ee_wr} <= 4'h0;
    @(posedge clk);
    check("pm read data", pm_rdata, pm_e);
    check("ee read data", ee_rdata, ee_e);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_blank();
    rdchk(IDX_CFG1, 32'h3FFF, "cfg1 blank");
    rdchk(IDX_CFG2, 32'h3FFF, "cfg2 blank");
    rdchk(IDX_IDWORD, ID_T, "id word");
    wr(IDX_IDWORD, 32'h0000_0000);
    rdchk(IDX_IDWORD, ID_T, "id after write");
    apb(1'b0, 16'h8004, 32'h0000_0000);
    check("unmapped error", err_v, 1'b1);
    check("cap blank", st.regulator_cap_pin_select, CAP_ON_NONE);
    $display("blank test done");
  endtask

  task automatic t_osc();
    for (int f = 0; f < 8; f++) begin
      wr(IDX_CFG1, 32'h3FF8 | f);
      do_reset(4);
      check("osc mode", st.osc_select_field, 32'h1 << f);
    end
    $display("oscillator test done");
  endtask

  task automatic t_cfg2();
    logic [WORD_W-1:0] lim [4] = '{14'h1000, 14'h0800, 14'h0200, 14'h0000};
    for (int k = 0; k < 4; k++) begin
      wr(IDX_CFG2, 32'h3FCC | (k << 4) | k);
      do_reset(4);
      rdchk(IDX_CFG2, 32'h3FCC | (k << 4) | k, "cfg2 readback");
      check("cap pin", st.regulator_cap_pin_select, 32'h1 << k);
      sw_req <= 1'b1;
      sw_addr <= 13'(lim[k] - 14'h0001);
      @(posedge clk);
      check("grant below limit", grant, k == 3);
      sw_addr <= lim[k][CPU_AW-1:0];
      @(posedge clk);
      check("grant at limit", grant, 1'b1);
      sw_req <= 1'b0;
    end
    wr(IDX_CFG2, 32'h0000_0000);
    do_reset(4);
    rdchk(IDX_CFG2, 32'h08CC, "cfg2 zero");
    check("lowv off", {st.low_voltage_prog_enable, hv}, 32'h1);
    check("dbg bor stack pll", {st.dbg_pins_gpio, st.brownout_threshold_select,
      st.stack_fault_reset_enable, st.multiplier_enable}, 32'h0);
    stack_pulse(1'b0);
    $display("word two test done");
  endtask

  task automatic t_lowv();
    lowv_pin <= 1'b1;
    repeat (8) @(posedge clk);
    wr(IDX_CFG2, 32'h0000_0000);
    rdchk(IDX_STATUS, 32'h3, "refused status");
    lowv_pin <= 1'b0;
    do_reset(4);
    rdchk(IDX_CFG2, 32'h28CC, "lowv kept");
    check("hv required", hv, 1'b0);
    $display("lowv test done");
  endtask

  task automatic t_prot();
    int b;
    for (int i = 0; i < 4; i++) begin
      wr(IDX_UID0 + 16'(i), 32'h1230 + i);
      rdchk(IDX_UID0 + 16'(i), 32'h1230 + i, "user id");
    end
    wr(IDX_CFG1, 32'h3E7F);
    do_reset(4);
    ext_acc(1'b0, 1'b0);
    b = n_pmer;
    wr(IDX_CFG1, 32'h3FFF);
    repeat (2) @(posedge clk);
    check("erase on unprotect", n_pmer - b, 32'h1);
    b = n_eeer;
    wr(IDX_ERASE, 32'h1);
    repeat (2) @(posedge clk);
    check("eeprom erased", n_eeer - b, 32'h1);
    rdchk(IDX_UID3, 32'h3FFF, "user id erased");
    do_reset(4);
    rdchk(IDX_CFG1, 32'h3FFF, "cfg1 erased");
    ext_acc(1'b1, 1'b1);
    stack_pulse(1'b1);
    $display("protection test done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    do_reset(16);
    t_blank();
    t_osc();
    t_cfg2();
    t_lowv();
    t_prot();
    results();
  end

  // Run needs about 250 cycles; this leaves wide margin
  initial begin
    #400000;
    n_fail++;
    results();
  end
endmodule
